// file: rtl/phy_mgmt_consts.svh
// offsets, field positions and reset values of the phy management bank
`ifndef PHY_MGMT_CONSTS_SVH
`define PHY_MGMT_CONSTS_SVH
// ==========================================================================
// What this block does
// - control bit 9 restarts autoneg, self clears
// - bit 8 picks duplex when autoneg off
// - single duplex ability pins bit 8 value
// - loopback makes duplex bit irrelevant
// - bit 7 forces collision with transmit enable
// - status bits 14:11 read ABLE, all one by default
// - status bit 6 reads zero
// - status bit 5 shows autoneg complete
// - status bit 4 reads zero
// - status bits 3 and 0 read one
// - status bit 2 latches link loss low
// - status bit 1 latches jabber high
// - registers 2 and 3 return fixed identifier
// - advertisement bit 15 constant zero
// - advertisement bit 13 writable remote fault
// - advertisement bits 12:5 writable, reset 00101111
// - advertisement selector fixed at 00001b
// - autoneg enabled, loopback off, ignores forced speed, duplex
// - latched bits hold until read clears
// - registers reached over management interface

// ==========================================================================
// register map
`define ADDR_W 5
`define DATA_W 16
`define REG_CTRL 5'h00
`define REG_STAT 5'h01
`define REG_ID_HI 5'h02
`define REG_ID_LO 5'h03
`define REG_ADV 5'h04

// ==========================================================================
// control fields
`define CTL_RESET 15
`define CTL_LOOP 14
`define CTL_SPEED 13
`define CTL_AN_EN 12
`define CTL_PDOWN 11
`define CTL_AN_RESTART 9
`define CTL_DUPLEX 8
`define CTL_COL_TEST 7
`define CTL_RST_VAL 16'h3000
`define CTL_WR_MASK 16'h7dff

// ==========================================================================
// status fields
`define STAT_ABLE_HI 14
`define STAT_ABLE_LO 11
`define STAT_PRE_SUP 6
`define STAT_AN_DONE 5
`define STAT_RFAULT 4
`define STAT_AN_ABLE 3
`define STAT_LINK 2
`define STAT_JABBER 1
`define STAT_EXT_CAP 0

// ==========================================================================
// advertisement fields
`define ADV_NEXT_PAGE 15
`define ADV_RFAULT 13
`define ADV_TECH_HI 12
`define ADV_TECH_LO 5
`define ADV_SEL_HI 4
`define ADV_TECH_RST 8'h2f
`define ADV_SEL_VAL 5'h01

`endif

// file: rtl/phy_mgmt_pkg.sv
// types shared by the phy management bank
`include "phy_mgmt_consts.svh"
package phy_mgmt_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
  } mgmt_req_t;

  typedef struct packed {
    logic an_done;
    logic link_ok;
    logic jabber;
    logic an_speed_100;
    logic an_full_duplex;
  } line_stat_t;

  typedef struct packed {
    logic an_restart;
    logic an_enable;
    logic loopback;
    logic speed_100;
    logic full_duplex;
    logic power_down;
  } phy_mode_t;

  typedef struct packed {
    logic [`DATA_W-1:0] ctrl;
    logic adv_rf;
    logic [7:0] adv_tech;
    logic [`DATA_W-1:0] rdata;
    logic ack;
    logic col;
    phy_mode_t mode;
  } bank_state_t;

  typedef struct packed {
    logic lat;
  } latch_state_t;

endpackage : phy_mgmt_pkg

// file: rtl/latch_flag.sv
// one latching status flag, cleared by a read of its register
`timescale 1ns/100ps
module latch_flag
  import phy_mgmt_pkg::*;
#(
  parameter logic EV_VAL = 1'b1
)
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // event and read clear
  input wire logic ev_i,
  input wire logic clr_i,
  // latched value
  output logic flag_o
);

  latch_state_t st_r;
  latch_state_t st_nxt;

  // ==========================================================================
  // latch
  // event beats a read in the same cycle so nothing is lost
  always_comb
  begin
    st_nxt = st_r;
    if (ev_i)
    begin
      st_nxt.lat = EV_VAL;
    end
    else if (clr_i)
    begin
      st_nxt.lat = ~EV_VAL;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign flag_o = st_r.lat;

endmodule : latch_flag

// file: rtl/phy_mgmt_ctrl_status_regs.sv
// management control, status, identifier and advertisement registers
`timescale 1ns/100ps
`include "phy_mgmt_consts.svh"
module phy_mgmt_ctrl_status_regs
  import phy_mgmt_pkg::*;
#(
  // identifier values are arbitrary
  parameter logic [`DATA_W-1:0] ID_HI = 16'h1234,
  parameter logic [`DATA_W-1:0] ID_LO = 16'h5678,
  // abilities: 100 fd, 100 hd, 10 fd, 10 hd
  parameter logic [3:0] ABLE = 4'hf
)
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // management access
  input wire mgmt_req_t mgmt_req_i,
  output logic [`DATA_W-1:0] mgmt_rdata_o,
  output logic mgmt_ack_o,
  // line side status
  input wire line_stat_t line_i,
  input wire logic tx_en_i,
  input wire logic line_col_i,
  // mode and line outputs
  output phy_mode_t mode_o,
  output logic col_o,
  output logic [`DATA_W-1:0] adv_word_o
);

  bank_state_t st_r;
  bank_state_t st_nxt;
  logic link_lat;
  logic jab_lat;
  logic stat_rd;
  logic [1:0] flag_ev;
  logic [1:0] flag_q;
  logic [`DATA_W-1:0] stat_word;
  logic [`DATA_W-1:0] adv_word;
  logic [`DATA_W-1:0] rd_word;
  logic fd_only;
  logic hd_only;

  // ==========================================================================
  // latching status flags
  assign stat_rd = mgmt_req_i.rd && (mgmt_req_i.addr == `REG_STAT);
  assign flag_ev = {~line_i.link_ok, line_i.jabber};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_flag
      // index 1 latches low on link loss, index 0 latches high on jabber
      latch_flag #(
        .EV_VAL((gi == 1) ? 1'b0 : 1'b1)
      ) u_flag (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .ev_i(flag_ev[gi]),
        .clr_i(stat_rd),
        .flag_o(flag_q[gi])
      );
    end
  endgenerate

  assign link_lat = flag_q[1];
  assign jab_lat = flag_q[0];

  // ==========================================================================
  // read words
  assign fd_only = (ABLE[3] | ABLE[1]) & ~(ABLE[2] | ABLE[0]);
  assign hd_only = (ABLE[2] | ABLE[0]) & ~(ABLE[3] | ABLE[1]);

  always_comb
  begin
    stat_word = '0;
    stat_word[`STAT_ABLE_HI:`STAT_ABLE_LO] = ABLE;
    stat_word[`STAT_PRE_SUP] = 1'b0;
    stat_word[`STAT_AN_DONE] = line_i.an_done;
    stat_word[`STAT_RFAULT] = 1'b0;
    stat_word[`STAT_AN_ABLE] = 1'b1;
    stat_word[`STAT_LINK] = link_lat;
    stat_word[`STAT_JABBER] = jab_lat;
    stat_word[`STAT_EXT_CAP] = 1'b1;
  end

  always_comb
  begin
    adv_word = '0;
    adv_word[`ADV_NEXT_PAGE] = 1'b0;
    adv_word[`ADV_RFAULT] = st_r.adv_rf;
    adv_word[`ADV_TECH_HI:`ADV_TECH_LO] = st_r.adv_tech;
    adv_word[`ADV_SEL_HI:0] = `ADV_SEL_VAL;
  end

  always_comb
  begin
    case (mgmt_req_i.addr)
      `REG_CTRL: rd_word = st_r.ctrl;
      `REG_STAT: rd_word = stat_word;
      `REG_ID_HI: rd_word = ID_HI;
      `REG_ID_LO: rd_word = ID_LO;
      `REG_ADV: rd_word = adv_word;
      default: rd_word = '0;
    endcase
  end

  // ==========================================================================
  // register updates and mode decode
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.ack = mgmt_req_i.rd | mgmt_req_i.wr;
    st_nxt.mode.an_restart = 1'b0;
    if (mgmt_req_i.rd)
    begin
      st_nxt.rdata = rd_word;
    end
    if (mgmt_req_i.wr)
    begin
      case (mgmt_req_i.addr)
        `REG_CTRL:
        begin
          if (mgmt_req_i.wdata[`CTL_RESET])
          begin
            // soft reset completes in one cycle, so the bit never reads one
            st_nxt.ctrl = `CTL_RST_VAL;
            st_nxt.adv_rf = 1'b0;
            st_nxt.adv_tech = `ADV_TECH_RST;
          end
          else
          begin
            // restart is a pulse, never stored: reads back zero
            st_nxt.ctrl = mgmt_req_i.wdata & `CTL_WR_MASK;
            st_nxt.mode.an_restart = mgmt_req_i.wdata[`CTL_AN_RESTART];
          end
        end
        `REG_ADV:
        begin
          st_nxt.adv_rf = mgmt_req_i.wdata[`ADV_RFAULT];
          st_nxt.adv_tech = mgmt_req_i.wdata[`ADV_TECH_HI:`ADV_TECH_LO];
        end
        default:
        begin
          st_nxt.ctrl = st_r.ctrl;
        end
      endcase
    end
    if (fd_only)
    begin
      st_nxt.ctrl[`CTL_DUPLEX] = 1'b1;
    end
    else if (hd_only)
    begin
      st_nxt.ctrl[`CTL_DUPLEX] = 1'b0;
    end
    st_nxt.mode.an_enable = st_r.ctrl[`CTL_AN_EN];
    st_nxt.mode.loopback = st_r.ctrl[`CTL_LOOP];
    st_nxt.mode.power_down = st_r.ctrl[`CTL_PDOWN];
    if (st_r.ctrl[`CTL_LOOP])
    begin
      // loopback runs full duplex whatever the duplex bit holds
      st_nxt.mode.full_duplex = 1'b1;
      st_nxt.mode.speed_100 = st_r.ctrl[`CTL_SPEED];
    end
    else if (st_r.ctrl[`CTL_AN_EN])
    begin
      st_nxt.mode.full_duplex = line_i.an_full_duplex;
      st_nxt.mode.speed_100 = line_i.an_speed_100;
    end
    else
    begin
      st_nxt.mode.full_duplex = st_r.ctrl[`CTL_DUPLEX];
      st_nxt.mode.speed_100 = st_r.ctrl[`CTL_SPEED];
    end
    st_nxt.col = line_col_i | (st_r.ctrl[`CTL_COL_TEST] & tx_en_i);
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      st_r <= '0;
      st_r.ctrl <= `CTL_RST_VAL;
      st_r.adv_tech <= `ADV_TECH_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign mgmt_rdata_o = st_r.rdata;
  assign mgmt_ack_o = st_r.ack;
  assign mode_o = st_r.mode;
  assign col_o = st_r.col;
  assign adv_word_o = adv_word;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);

  logic wr_ctrl;
  logic rd_stat;
  logic rd_adv;
  assign wr_ctrl = mgmt_req_i.wr && (mgmt_req_i.addr == `REG_CTRL);
  assign rd_stat = stat_rd;
  assign rd_adv = mgmt_req_i.rd && (mgmt_req_i.addr == `REG_ADV);

  property p_an_restart;
    wr_ctrl && mgmt_req_i.wdata[`CTL_AN_RESTART] && !mgmt_req_i.wdata[`CTL_RESET]
      |=> mode_o.an_restart && !st_r.ctrl[`CTL_AN_RESTART];
  endproperty
  a_an_restart: assert property (p_an_restart)
    else $error("restart pulse missing or bit stored");

  // back-to-back restart writes keep the pulse high, so only a quiet cycle must clear it
  property p_an_self_clear;
    !(wr_ctrl && mgmt_req_i.wdata[`CTL_AN_RESTART]) |=> !mode_o.an_restart;
  endproperty
  a_an_self_clear: assert property (p_an_self_clear)
    else $error("restart pulse did not clear");

  property p_forced_duplex;
    !st_r.ctrl[`CTL_AN_EN] && !st_r.ctrl[`CTL_LOOP]
      |=> mode_o.full_duplex == $past(st_r.ctrl[`CTL_DUPLEX]);
  endproperty
  a_forced_duplex: assert property (p_forced_duplex)
    else $error("forced duplex not applied");

  property p_loop_duplex;
    st_r.ctrl[`CTL_LOOP] |=> mode_o.full_duplex;
  endproperty
  a_loop_duplex: assert property (p_loop_duplex)
    else $error("loopback duplex follows control bit");

  property p_an_ignores_force;
    st_r.ctrl[`CTL_AN_EN] && !st_r.ctrl[`CTL_LOOP]
      |=> mode_o.speed_100 == $past(line_i.an_speed_100)
        && mode_o.full_duplex == $past(line_i.an_full_duplex);
  endproperty
  a_an_ignores_force: assert property (p_an_ignores_force)
    else $error("forced bits used during autoneg");

  property p_col_test;
    st_r.ctrl[`CTL_COL_TEST] && tx_en_i |=> col_o;
  endproperty
  a_col_test: assert property (p_col_test)
    else $error("collision not forced");

  property p_no_col;
    !st_r.ctrl[`CTL_COL_TEST] && !line_col_i |=> !col_o;
  endproperty
  a_no_col: assert property (p_no_col)
    else $error("collision forced while test off");

  property p_stat_fixed;
    rd_stat |=> mgmt_ack_o && mgmt_rdata_o[`STAT_ABLE_HI:`STAT_ABLE_LO] == ABLE
      && !mgmt_rdata_o[`STAT_PRE_SUP] && !mgmt_rdata_o[`STAT_RFAULT]
      && mgmt_rdata_o[`STAT_AN_ABLE] && mgmt_rdata_o[`STAT_EXT_CAP];
  endproperty
  a_stat_fixed: assert property (p_stat_fixed)
    else $error("fixed status bits wrong");

  property p_an_done;
    rd_stat |=> mgmt_rdata_o[`STAT_AN_DONE] == $past(line_i.an_done);
  endproperty
  a_an_done: assert property (p_an_done)
    else $error("autoneg complete bit wrong");

  property p_link_ll;
    !line_i.link_ok ##1 rd_stat |=> !mgmt_rdata_o[`STAT_LINK];
  endproperty
  a_link_ll: assert property (p_link_ll)
    else $error("link loss not latched");

  property p_jab_lh;
    line_i.jabber ##1 rd_stat |=> mgmt_rdata_o[`STAT_JABBER];
  endproperty
  a_jab_lh: assert property (p_jab_lh)
    else $error("jabber not latched");

  property p_id;
    mgmt_req_i.rd && mgmt_req_i.addr == `REG_ID_HI |=> mgmt_rdata_o == ID_HI;
  endproperty
  a_id: assert property (p_id)
    else $error("identifier wrong");

  property p_adv_write;
    mgmt_req_i.wr && mgmt_req_i.addr == `REG_ADV ##1 rd_adv && !mgmt_req_i.wr
      |=> mgmt_rdata_o[`ADV_TECH_HI:`ADV_TECH_LO]
          == $past(mgmt_req_i.wdata[`ADV_TECH_HI:`ADV_TECH_LO], 2)
        && mgmt_rdata_o[`ADV_RFAULT] == $past(mgmt_req_i.wdata[`ADV_RFAULT], 2);
  endproperty
  a_adv_write: assert property (p_adv_write)
    else $error("advertisement write lost");

  property p_adv_fixed;
    rd_adv |=> !mgmt_rdata_o[`ADV_NEXT_PAGE]
      && mgmt_rdata_o[`ADV_SEL_HI:0] == `ADV_SEL_VAL && !mgmt_rdata_o[14];
  endproperty
  a_adv_fixed: assert property (p_adv_fixed)
    else $error("fixed advertisement bits wrong");

  c_restart: cover property (wr_ctrl && mgmt_req_i.wdata[`CTL_AN_RESTART]);
  c_col: cover property (st_r.ctrl[`CTL_COL_TEST] && tx_en_i ##1 col_o);
  c_link_read: cover property (!line_i.link_ok ##1 line_i.link_ok ##1 rd_stat);
  c_adv_rw: cover property (mgmt_req_i.wr && mgmt_req_i.addr == `REG_ADV ##1 rd_adv);

endmodule : phy_mgmt_ctrl_status_regs

// file: sim/tb_top.sv
// self-checking bench for the phy management register bank
`timescale 1ns/100ps
module tb_top
  import phy_mgmt_pkg::*;
;
  // ==========================================================================
  // stimulus and design
  // identifier values are arbitrary
  localparam logic [15:0] id_hi = 16'h2b6c;
  localparam logic [15:0] id_lo = 16'h7e13;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  mgmt_req_t mgmt_req_i = '0;
  line_stat_t line_i = 5'b01000;
  logic tx_en_i = 1'b0;
  logic line_col_i = 1'b0;
  logic [15:0] mgmt_rdata_o;
  logic mgmt_ack_o;
  phy_mode_t mode_o;
  logic col_o;
  logic [15:0] adv_word_o;
  int err_total = 0;
  int checked = 0;
  int seed = 32'h395a79e1;
  logic [15:0] ctl_tab [7] = '{16'h1000, 16'h1100, 16'h2100, 16'h0000, 16'h4000,
    16'h6800, 16'h0100};
  logic [4:0] rd_tab [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h1f, 5'h01};

  always #20 mclk_i = ~mclk_i;

  phy_mgmt_ctrl_status_regs #(
    .ID_HI(id_hi),
    .ID_LO(id_lo),
    .ABLE(4'hf)
  ) u_phy_mgmt_ctrl_status_regs (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .mgmt_req_i(mgmt_req_i),
    .mgmt_rdata_o(mgmt_rdata_o),
    .mgmt_ack_o(mgmt_ack_o),
    .line_i(line_i),
    .tx_en_i(tx_en_i),
    .line_col_i(line_col_i),
    .mode_o(mode_o),
    .col_o(col_o),
    .adv_word_o(adv_word_o)
  );

  // ==========================================================================
  // behavioural model, updated on the sampling edge
  logic [15:0] ctrl_m;
  logic [15:0] adv_m;
  logic [15:0] exp_rd;
  logic exp_ack;
  logic exp_col;
  logic exp_rs;
  logic lnk_m;
  logic jab_m;

  function automatic logic [15:0] rd_val(input logic [4:0] a);
    case (a)
      5'h00: return ctrl_m;
      5'h01: return {5'b01111, 4'h0, 1'b0, line_i.an_done, 1'b0, 1'b1, lnk_m, jab_m, 1'b1};
      5'h02: return id_hi;
      5'h03: return id_lo;
      5'h04: return adv_m;
      default: return 16'h0000;
    endcase
  endfunction : rd_val

  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      ctrl_m = 16'h3000;
      adv_m = 16'h05e1;
      exp_rd = 16'h0000;
      {exp_ack, exp_col, exp_rs, lnk_m, jab_m} = 5'h00;
    end
    else
    begin
      exp_ack = mgmt_req_i.wr | mgmt_req_i.rd;
      exp_col = line_col_i | (ctrl_m[7] & tx_en_i);
      exp_rs = mgmt_req_i.wr && mgmt_req_i.addr == 5'h00 && mgmt_req_i.wdata[9]
        && !mgmt_req_i.wdata[15];
      // read sees the value from before any write in the same cycle
      if (mgmt_req_i.rd)
        exp_rd = rd_val(mgmt_req_i.addr);
      if (mgmt_req_i.wr && mgmt_req_i.addr == 5'h00)
      begin
        ctrl_m = mgmt_req_i.wdata[15] ? 16'h3000 : (mgmt_req_i.wdata & 16'h7dff);
        if (mgmt_req_i.wdata[15])
          adv_m = 16'h05e1;
      end
      if (mgmt_req_i.wr && mgmt_req_i.addr == 5'h04)
        adv_m = {2'b00, mgmt_req_i.wdata[13:5], 5'h01};
      // an event in the read cycle wins over the read clear
      if (!line_i.link_ok)
        lnk_m = 1'b0;
      else if (mgmt_req_i.rd && mgmt_req_i.addr == 5'h01)
        lnk_m = 1'b1;
      if (line_i.jabber)
        jab_m = 1'b1;
      else if (mgmt_req_i.rd && mgmt_req_i.addr == 5'h01)
        jab_m = 1'b0;
    end
  end

  function automatic phy_mode_t mode_exp(input logic [15:0] c);
    phy_mode_t m;
    m.an_restart = 1'b0;
    m.an_enable = c[12];
    m.loopback = c[14];
    m.power_down = c[11];
    m.speed_100 = (c[12] && !c[14]) ? line_i.an_speed_100 : c[13];
    m.full_duplex = c[14] ? 1'b1 : (c[12] ? line_i.an_full_duplex : c[8]);
    return m;
  endfunction : mode_exp

  // ==========================================================================
  // comparison and closing
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  // every result is compared on the falling edge, once outputs have settled
  always @(negedge mclk_i)
  begin
    if (!sys_rst_i)
    begin
      chk(16'(mgmt_ack_o), 16'(exp_ack));
      chk(mgmt_rdata_o, exp_rd);
      chk(16'(col_o), 16'(exp_col));
      chk(16'(mode_o.an_restart), 16'(exp_rs));
      chk(adv_word_o, adv_m);
    end
  end

  // ==========================================================================
  // main sequence
  task automatic op(input logic w, input logic r, input logic [4:0] a, input logic [15:0] d);
    @(negedge mclk_i);
    mgmt_req_i = '{wr: w, rd: r, addr: a, wdata: d};
  endtask : op

  initial
  begin
    logic [15:0] d;
    logic [4:0] a;
    repeat (12) @(posedge mclk_i);
    @(negedge mclk_i);
    sys_rst_i = 1'b0;
    // reset values, unmapped reads, link latch re-armed by the first status read
    foreach (rd_tab[i])
      op(1'b0, 1'b1, rd_tab[i], 16'h0000);
    // random back-to-back traffic with moving line status
    for (int i = 0; i < 400; i++)
    begin
      d = 16'($random(seed));
      a = 5'($random(seed) & 7);
      if (a == 5'h00)
        d = d & 16'h7b80;
      op(1'($random(seed)), 1'($random(seed)), a, d);
      line_i = 5'($random(seed));
      tx_en_i = 1'($random(seed));
      line_col_i = 1'($random(seed) % 4 == 0);
    end
    // bit 15 brings control and advertisement back to defaults
    op(1'b1, 1'b0, 5'h04, 16'hffff);
    op(1'b1, 1'b1, 5'h00, 16'h8000);
    op(1'b0, 1'b1, 5'h00, 16'h0000);
    op(1'b0, 1'b1, 5'h04, 16'h0000);
    // mode decode with stable line status
    line_i = 5'b11010;
    tx_en_i = 1'b0;
    line_col_i = 1'b0;
    foreach (ctl_tab[i])
    begin
      op(1'b1, 1'b0, 5'h00, ctl_tab[i]);
      repeat (3) op(1'b0, 1'b0, 5'h00, 16'h0000);
      chk(16'(mode_o), 16'(mode_exp(ctl_tab[i])));
    end
    repeat (2) op(1'b0, 1'b0, 5'h00, 16'h0000);
    final_report();
  end

  // hang guard, far beyond the few hundred cycles the sequence needs
  initial
  begin
    #(40 * 4000);
    err_total++;
    final_report();
  end
endmodule : tb_top
